// ### logic/adc_trig_ctrl.sv
/*
 Converter trigger, delay, acquisition and result compare control.
 Assumes a byte-wide special function register port on clk_sys, an
 analog macro that answers convert_go with analog_done and its result
 on the same clock, and a PWM unit that takes brake and run clear.
*/
// Operation
// - Route bit picks start pin from port P0.4 or P1.3, instantly.
// - Divide code 00..11 gives converter clock of system /1,/2,/4,/8.
// - Type 00 starts on falling edge, 01 on rising edge of source.
// - Type 10 starts at PWM period centre, 11 at period end.
// - Centre and end triggers only occur in center-aligned PWM mode.
// - External enable 0 allows software start only; 1 adds triggers.
// - Triggers during busy are silently discarded until busy clears.
// - Power bit switches the converter circuit off at 0, on at 1.
// - Brake enable with compare output 1 asserts brake, clears run.
// - Polarity 0: result >= compare value; polarity 1: result less.
// - With gate on, done flag sets only when the compare holds.
// - With gate on, conversions repeat back to back until done sets.
// - Compare output is re-evaluated at every conversion completion.
// - Acquisition lasts four times field plus six converter clocks.
// - Control two bit 0 is delay count bit 8 above low byte.
// - External trigger waits nine-bit delay count converter clocks.
// - Start bit write 1 starts, reads busy, clears at completion.
// - Done flag set at completion, cleared by software, blocks starts.
// - Source code 00,01,10 picks PWM channel 0,2,4; 11 the pin.
`timescale 1ns/1ps
`default_nettype none

module adc_trig_ctrl
   import adc_trig_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Special function register port
   input wire sfr_req_t sfr_req,
   output logic [7:0] sfr_rdata,
   // Start pins and PWM unit
   input wire logic pin_p04,
   input wire logic pin_p13,
   input wire pwm_in_t pwm_in,
   output logic fault_brake,
   output logic pwm_run_clear,
   // Analog macro
   input wire logic analog_done,
   input wire logic [11:0] analog_result,
   input wire logic [11:0] compare_value,
   output analog_ctl_t analog_ctl,
   // Results
   output logic [11:0] conversion_result,
   output logic conversion_done_flag
);

`include "adc_trig_consts.svh"

   typedef struct packed {
      ctrl_one_t c1;
      ctrl_two_t c2;
      trig_src_t src;
      logic done;
      logic busy;
      logic [7:0] delay_low;
      conv_state_t st;
      logic [2:0] div_cnt;
      logic [8:0] delay_cnt;
      logic [5:0] aqt_cnt;
      logic trig_prev;
      logic [11:0] result;
      logic [7:0] rdata;
      logic brake;
      logic run_clear;
      logic tick;
      logic go;
      logic sample;
   } atc_state_t;

   atc_state_t s;
   atc_state_t next_s;

   // -----------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------
   function automatic logic compare_met(input logic [11:0] res,
                                        input logic [11:0] ref_val,
                                        input logic pol);
      compare_met = pol ? (res < ref_val) : (res >= ref_val);
   endfunction

   function automatic logic [5:0] aqt_cycles(input logic [2:0] field);
      aqt_cycles = ({3'h0, field} << `ATC_AQT_SHIFT) + `ATC_AQT_BASE;
   endfunction

   // -----------------------------------------------------------------
   // Input synchronisation
   // -----------------------------------------------------------------
   logic [7:0] raw_bus;
   logic [7:0] sync_bus;

   assign raw_bus = {pin_p04, pin_p13, pwm_in.chan, pwm_in.center_point,
                     pwm_in.period_end, pwm_in.center_aligned};

   adc_trig_sync #(
      .WIDTH(8)
   ) u_sync (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .raw_in(raw_bus),
      .settled(sync_bus)
   );

   logic sy_p04;
   logic sy_p13;
   logic [2:0] sy_chan;
   logic sy_center;
   logic sy_end;
   logic sy_aligned;

   assign {sy_p04, sy_p13, sy_chan, sy_center, sy_end, sy_aligned} =
      sync_bus;

   // -----------------------------------------------------------------
   // Trigger selection and edge detection
   // -----------------------------------------------------------------
   logic pin_level;
   logic src_level;
   logic trig_level;
   logic trig_edge;
   logic ext_fire;
   logic sw_write;
   logic sw_start;
   logic can_start;
   logic [8:0] delay_full;

   always_comb begin
      // start pin routing, no extra register in the path
      pin_level = s.c1.start_pin_route_sel ? sy_p13 : sy_p04;
      unique case (s.src)
         SRC_PWM_CH0: src_level = sy_chan[0];
         SRC_PWM_CH2: src_level = sy_chan[1];
         SRC_PWM_CH4: src_level = sy_chan[2];
         SRC_START_PIN: src_level = pin_level;
      endcase
      unique case (trig_type_t'(s.c1.trigger_condition_type))
         TRIG_CENTER: trig_level = sy_center & sy_aligned;
         TRIG_PERIOD_END: trig_level = sy_end & sy_aligned;
         default: trig_level = src_level;
      endcase
      // falling edge for type 00, rising otherwise
      if (trig_type_t'(s.c1.trigger_condition_type) == TRIG_FALL) begin
         trig_edge = s.trig_prev & ~trig_level;
      end else begin
         trig_edge = ~s.trig_prev & trig_level;
      end
   end

   // bit 8 of the delay sits in control two
   assign delay_full = {s.c2.delay_bit8, s.delay_low};
   assign sw_write = sfr_req.wr && (sfr_req.addr == `ATC_OFS_CTRL_ZERO);
   // done flag blocks starts; nothing runs powered off
   assign can_start = !s.busy && !s.done && s.c1.converter_power_on;
   assign sw_start = sw_write && sfr_req.wdata[`ATC_CZ_START_BIT] &&
                     can_start;
   // external triggers only with enable; dropped if busy
   assign ext_fire = s.c1.external_trigger_enable && trig_edge &&
                     can_start && !sw_start;

   // -----------------------------------------------------------------
   // Next state
   // -----------------------------------------------------------------
   logic cmp_now;
   logic met_now;

   always_comb begin
      next_s = s;
      next_s.brake = 1'b0;
      next_s.run_clear = 1'b0;
      next_s.go = 1'b0;
      next_s.trig_prev = trig_level;
      cmp_now = compare_met(analog_result, compare_value,
                            s.c2.compare_polarity);
      // gate makes the flag depend on the compare
      met_now = !s.c2.compare_gate_enable || cmp_now;

      // tick every 1, 2, 4 or 8 system clocks
      next_s.div_cnt = s.div_cnt + 3'h1;
      next_s.tick = (s.div_cnt & 3'((4'h1 << s.c1.converter_clock_divide)
                     - 4'h1)) == 3'((4'h1 << s.c1.converter_clock_divide)
                     - 4'h1);

      // Register writes
      if (sfr_req.wr) begin
         unique case (sfr_req.addr)
            `ATC_OFS_CTRL_ZERO: begin
               next_s.src = trig_src_t'(
                  sfr_req.wdata[`ATC_CZ_SRC_MSB:`ATC_CZ_SRC_LSB]);
               if (!sfr_req.wdata[`ATC_CZ_DONE_BIT]) begin
                  next_s.done = 1'b0;
               end
            end
            `ATC_OFS_CTRL_ONE: next_s.c1 = ctrl_one_t'(sfr_req.wdata);
            `ATC_OFS_CTRL_TWO: begin
               // Compare output is read only
               next_s.c2 = ctrl_two_t'(sfr_req.wdata);
               next_s.c2.compare_output = s.c2.compare_output;
            end
            `ATC_OFS_DELAY_LOW: next_s.delay_low = sfr_req.wdata;
            default: ;
         endcase
      end

      // Register reads, value before this cycle's write
      if (sfr_req.rd) begin
         unique case (sfr_req.addr)
            `ATC_OFS_CTRL_ZERO: next_s.rdata = {s.done, s.busy, s.src, 4'h0};
            `ATC_OFS_CTRL_ONE: next_s.rdata = s.c1;
            `ATC_OFS_CTRL_TWO: next_s.rdata = s.c2;
            `ATC_OFS_DELAY_LOW: next_s.rdata = s.delay_low;
            default: next_s.rdata = 8'h00;
         endcase
      end

      // Conversion sequencing
      unique case (s.st)
         ST_IDLE: begin
            if (sw_start) begin
               next_s.busy = 1'b1;
               next_s.st = ST_ACQUIRE;
               next_s.aqt_cnt = aqt_cycles(s.c2.acquire_time_field);
            end else if (ext_fire) begin
               // delay only on the external path
               next_s.busy = 1'b1;
               next_s.st = ST_DELAY;
               next_s.delay_cnt = delay_full;
            end
         end
         ST_DELAY: begin
            if (s.delay_cnt == 9'h000) begin
               next_s.st = ST_ACQUIRE;
               next_s.aqt_cnt = aqt_cycles(s.c2.acquire_time_field);
            end else if (s.tick) begin
               next_s.delay_cnt = s.delay_cnt - 9'h001;
            end
         end
         ST_ACQUIRE: begin
            if (s.tick) begin
               if (s.aqt_cnt == 6'h01) begin
                  next_s.st = ST_CONVERT;
                  next_s.go = 1'b1;
               end else begin
                  next_s.aqt_cnt = s.aqt_cnt - 6'h01;
               end
            end
         end
         ST_CONVERT: begin
            if (analog_done) begin
               // result and compare bit land together
               next_s.result = analog_result;
               next_s.c2.compare_output = cmp_now;
               // brake and run clear from compare output
               if (s.c2.brake_on_compare_enable && cmp_now) begin
                  next_s.brake = 1'b1;
                  next_s.run_clear = 1'b1;
               end
               if (met_now) begin
                  next_s.busy = 1'b0;
                  next_s.done = 1'b1;
                  next_s.st = ST_IDLE;
               end else begin
                  // back to back until the compare holds
                  next_s.st = ST_ACQUIRE;
                  next_s.aqt_cnt = aqt_cycles(s.c2.acquire_time_field);
               end
            end
         end
      endcase

      if (!s.c1.converter_power_on && s.st != ST_IDLE) begin
         next_s.st = ST_IDLE;
         next_s.busy = 1'b0;
      end
      // Registered so the sampling switch sees no decode glitch
      next_s.sample = (next_s.st == ST_ACQUIRE);
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
         s.c1 <= ctrl_one_t'(`ATC_RST_CTRL_ONE);
         s.c2 <= ctrl_two_t'(`ATC_RST_CTRL_TWO);
         s.delay_low <= `ATC_RST_DELAY_LOW;
         s.st <= ST_IDLE;
      end else begin
         s <= next_s;
      end
   end

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   assign sfr_rdata = s.rdata;
   assign fault_brake = s.brake;
   assign pwm_run_clear = s.run_clear;
   assign conversion_result = s.result;
   assign conversion_done_flag = s.done;
   assign analog_ctl = '{power_on: s.c1.converter_power_on,
                         tick: s.tick, sample: s.sample, go: s.go};

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   logic [5:0] aqt_seen;
   logic completion;
   logic c1_write;

   assign completion = (s.st == ST_CONVERT) && analog_done &&
                       s.c1.converter_power_on;
   assign c1_write = sfr_req.wr && (sfr_req.addr == `ATC_OFS_CTRL_ONE);

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         aqt_seen <= 6'h00;
      end else if (s.st != ST_ACQUIRE) begin
         aqt_seen <= 6'h00;
      end else if (s.tick) begin
         aqt_seen <= aqt_seen + 6'h01;
      end
   end

   sequence seq_sw_start;
      s.st == ST_IDLE && sw_start;
   endsequence

   sequence seq_enter_acquire;
      s.busy && s.st == ST_ACQUIRE;
   endsequence

   chk_sw_start_busy: assert property (
      seq_sw_start |=> seq_enter_acquire)
      else $error("software start did not enter acquisition");

   // done flag holds the sequencer idle
   chk_done_blocks_start: assert property (
      (s.st == ST_IDLE && s.done) |=> s.st == ST_IDLE)
      else $error("conversion started while done flag set");

   chk_busy_ignore_trig: assert property (
      (s.st == ST_CONVERT && !analog_done && s.c1.converter_power_on)
      |=> s.st == ST_CONVERT && s.busy)
      else $error("conversion disturbed while busy");

   chk_acquire_length: assert property (
      (s.st == ST_ACQUIRE && s.tick && s.aqt_cnt == 6'h01)
      |-> aqt_seen + 6'h01 == aqt_cycles(s.c2.acquire_time_field))
      else $error("acquisition length wrong");

   chk_compare_polarity: assert property (
      completion |=> s.c2.compare_output == compare_met($past(analog_result),
         $past(compare_value), $past(s.c2.compare_polarity)))
      else $error("compare output wrong");

   // gate keeps converting while compare fails
   chk_gate_repeat: assert property (
      (completion && s.c2.compare_gate_enable && !cmp_now)
      |=> s.st == ST_ACQUIRE && !s.done && s.busy)
      else $error("gated conversion did not repeat");

   chk_brake_on_compare: assert property (
      (completion && s.c2.brake_on_compare_enable && cmp_now)
      |=> fault_brake && pwm_run_clear ##1 !fault_brake)
      else $error("brake not asserted on compare");

   chk_divide_by_two: assert property (
      (s.tick && s.c1.converter_clock_divide == 2'h1 && !c1_write &&
       !$past(c1_write))
      |=> !s.tick ##1 s.tick)
      else $error("divide by two tick spacing wrong");

   chk_result_update: assert property (
      completion |=> conversion_result == $past(analog_result))
      else $error("result not captured at completion");

endmodule

`default_nettype wire

// ### logic/adc_trig_consts.svh
/*
 Constants for the converter trigger and compare control: register
 offsets, field positions, reset values and timing counts.
 Assumes it is included by bare name inside module or package scope.
*/
`ifndef ADC_TRIG_CONSTS_SVH
`define ADC_TRIG_CONSTS_SVH

// -----------------------------------------------------------------
// Register offsets on the special function register bus
// -----------------------------------------------------------------
`define ATC_OFS_CTRL_ZERO 8'hE8
`define ATC_OFS_CTRL_ONE 8'hE1
`define ATC_OFS_CTRL_TWO 8'hE2
`define ATC_OFS_DELAY_LOW 8'hE3

// -----------------------------------------------------------------
// Field positions in control register zero
// -----------------------------------------------------------------
`define ATC_CZ_DONE_BIT 7
`define ATC_CZ_START_BIT 6
`define ATC_CZ_SRC_MSB 5
`define ATC_CZ_SRC_LSB 4

// -----------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------
`define ATC_RST_CTRL_ONE 8'h00
`define ATC_RST_CTRL_TWO 8'h00
`define ATC_RST_DELAY_LOW 8'h00

// -----------------------------------------------------------------
// Timing counts: acquisition in converter clock periods, synchroniser in clk_sys stages
// -----------------------------------------------------------------
`define ATC_AQT_BASE 6'h06
`define ATC_AQT_SHIFT 2
`define ATC_SYNC_STAGES 3

`endif

// ### logic/adc_trig_pkg.sv
/*
 Types shared by the converter trigger and compare control.
 Assumes adc_trig_consts.svh is on the include path.
*/
`default_nettype none

package adc_trig_pkg;

   // -----------------------------------------------------------------
   // Register layouts
   // -----------------------------------------------------------------
   typedef struct packed {
      logic spare_bit;
      logic start_pin_route_sel;
      logic [1:0] converter_clock_divide;
      logic [1:0] trigger_condition_type;
      logic external_trigger_enable;
      logic converter_power_on;
   } ctrl_one_t;

   typedef struct packed {
      logic brake_on_compare_enable;
      logic compare_polarity;
      logic compare_gate_enable;
      logic compare_output;
      logic [2:0] acquire_time_field;
      logic delay_bit8;
   } ctrl_two_t;

   // -----------------------------------------------------------------
   // Encodings
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      SRC_PWM_CH0, SRC_PWM_CH2, SRC_PWM_CH4, SRC_START_PIN
   } trig_src_t;

   typedef enum logic [1:0] {
      TRIG_FALL, TRIG_RISE, TRIG_CENTER, TRIG_PERIOD_END
   } trig_type_t;

   typedef enum logic [1:0] {
      ST_IDLE, ST_DELAY, ST_ACQUIRE, ST_CONVERT
   } conv_state_t;

   // -----------------------------------------------------------------
   // Carriers
   // -----------------------------------------------------------------
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sfr_req_t;

   typedef struct packed {
      logic [2:0] chan;
      logic center_point;
      logic period_end;
      logic center_aligned;
   } pwm_in_t;

   typedef struct packed {
      logic power_on;
      logic tick;
      logic sample;
      logic go;
   } analog_ctl_t;

endpackage

`default_nettype wire

// ### logic/adc_trig_sync.sv
/*
 Three-stage synchroniser bank with agreement filter.
 Assumes inputs are asynchronous to clk_sys; outputs are levels.
*/
`timescale 1ns/1ps
`default_nettype none

module adc_trig_sync #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Raw and settled levels
   input wire logic [WIDTH-1:0] raw_in,
   output logic [WIDTH-1:0] settled
);

   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] level;
   } sync_state_t;

   sync_state_t s;
   sync_state_t next_s;

   // -----------------------------------------------------------------
   // Agreement of stages two and three
   // -----------------------------------------------------------------
   always_comb begin
      next_s = s;
      next_s.s1 = raw_in;
      next_s.s2 = s.s1;
      next_s.s3 = s.s2;
      for (int i = 0; i < WIDTH; i++) begin
         // Stage one is never looked at: only stage two reads it
         if (s.s2[i] == s.s3[i]) begin
            next_s.level[i] = s.s3[i];
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign settled = s.level;

endmodule

`default_nettype wire

// ### dv/adc_trig_analog_model.sv
/*
 Analog macro stand-in: answers each go pulse with one done pulse.
 Assumes go and power_on come from the control block on clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none

module adc_trig_analog_model #(
   parameter int LAT = 5
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Control side
   input wire logic go,
   input wire logic power_on,
   input wire logic [11:0] res,
   // Answer side
   output logic done,
   output logic [11:0] result
);
   int cnt;
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 0;
         done <= 1'b0;
         result <= 12'hFFF;
      end else begin
         done <= 1'b0;
         // Result valid only with done, so it toggles in between
         result <= ~result;
         if (!power_on) cnt <= 0;
         else if (go) cnt <= LAT;
         else if (cnt > 0) cnt <= cnt - 1;
         if (cnt == 1 && power_on) begin
            done <= 1'b1;
            result <= res;
         end
      end
   end
endmodule
`default_nettype wire

// ### dv/adc_trig_ctrl_tb.sv
/*
 Self-checking bench for the converter trigger and compare control.
 Assumes the analog model on the far side and a 250 MHz clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none

module adc_trig_ctrl_tb;
   import adc_trig_pkg::*;
   logic clk_sys, rst_n, pin_p04, pin_p13, fault_brake, pwm_run_clear;
   logic analog_done, conversion_done_flag;
   sfr_req_t sfr_req;
   pwm_in_t pwm_in;
   analog_ctl_t analog_ctl;
   logic [7:0] sfr_rdata;
   logic [11:0] analog_result, conversion_result, model_res, res_a, res_b;
   logic [11:0] go_cnt = 12'h000, tick_cnt = 12'h000, brake_cnt = 12'h000;
   logic [11:0] run_clr_cnt = 12'h000, cyc = 12'h000, last_tick, tick_gap;
   logic [11:0] base_go, base_tick, base_brk, base_rc;
   int errors = 0, check_count = 0;
   assign model_res = (go_cnt - base_go <= 12'h001) ? res_a : res_b;

   adc_trig_ctrl i_adc_trig_ctrl (.clk_sys(clk_sys), .rst_n(rst_n),
      .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .pin_p04(pin_p04),
      .pin_p13(pin_p13), .pwm_in(pwm_in), .fault_brake(fault_brake),
      .pwm_run_clear(pwm_run_clear), .analog_done(analog_done),
      .analog_result(analog_result), .compare_value(12'h100),
      .analog_ctl(analog_ctl), .conversion_result(conversion_result),
      .conversion_done_flag(conversion_done_flag));
   adc_trig_analog_model i_adc_trig_analog_model (.clk_sys(clk_sys),
      .rst_n(rst_n), .go(analog_ctl.go), .power_on(analog_ctl.power_on),
      .res(model_res), .done(analog_done), .result(analog_result));

   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (analog_ctl.go) go_cnt <= go_cnt + 1;
      if (analog_ctl.sample && analog_ctl.tick) tick_cnt <= tick_cnt + 1;
      if (analog_ctl.tick) begin
         tick_gap <= cyc - last_tick;
         last_tick <= cyc;
      end
      if (fault_brake) brake_cnt <= brake_cnt + 1;
      if (pwm_run_clear) run_clr_cnt <= run_clr_cnt + 1;
   end

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic cmp(input logic [11:0] got, exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("Error %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, d);
      @(posedge clk_sys) #1;
      sfr_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk_sys) #1;
      sfr_req.wr = 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, exp);
      @(posedge clk_sys) #1;
      sfr_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk_sys) #1;
      sfr_req.rd = 1'b0;
      cmp({4'h0, sfr_rdata}, {4'h0, exp});
   endtask
   task automatic cycles(input int n);
      repeat (n) @(posedge clk_sys) #1;
   endtask
   task automatic wait_done();
      int n;
      n = 0;
      while (conversion_done_flag !== 1'b1 && n < 3000) begin
         cycles(1);
         n++;
      end
      cmp({11'h0, conversion_done_flag}, 12'h001);
   endtask
   task automatic sw_conv(input logic [7:0] e1, e2,
                          input logic [11:0] ra, rb);
      wr_reg(8'hE1, e1);
      wr_reg(8'hE2, e2);
      res_a = ra;
      res_b = rb;
      base_go = go_cnt;
      base_tick = tick_cnt;
      base_brk = brake_cnt;
      base_rc = run_clr_cnt;
      wr_reg(8'hE8, 8'h40);
      wait_done();
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_regs();
      rd_chk(8'hE1, 8'h00);
      rd_chk(8'hE2, 8'h00);
      rd_chk(8'h55, 8'h00);
      wr_reg(8'h55, 8'hFF);
      wr_reg(8'hE1, 8'hFE);
      rd_chk(8'hE1, 8'hFE);
      cmp({11'h0, analog_ctl.power_on}, 12'h000);
      wr_reg(8'hE2, 8'hFF);
      rd_chk(8'hE2, 8'hEF);
      wr_reg(8'hE2, 8'h00);
      $display("t_regs done");
   endtask
   task automatic t_div();
      for (int d = 0; d < 4; d++) begin
         // Acquisition field only changed while idle
         sw_conv({2'b00, d[1:0], 4'h1}, {4'h0, d[2:0], 1'b0}, 12'h0AB,
                 12'h0AB);
         cmp(tick_cnt - base_tick, 12'(4 * d + 6));
         cmp(tick_gap, 12'(1 << d));
         cmp(conversion_result, 12'h0AB);
         wr_reg(8'hE8, 8'h00);
         rd_chk(8'hE8, 8'h00);
      end
      $display("t_div done");
   endtask
   task automatic t_cmp();
      logic p, e;
      logic [11:0] r;
      for (int i = 0; i < 4; i++) begin
         p = i[1];
         r = i[0] ? 12'h0FF : 12'h100;
         e = p ? (r < 12'h100) : (r >= 12'h100);
         sw_conv(8'h01, {1'b1, p, 6'h00}, r, r);
         rd_chk(8'hE2, {1'b1, p, 1'b0, e, 4'h0});
         cmp(brake_cnt - base_brk, {11'h0, e});
         cmp(run_clr_cnt - base_rc, {11'h0, e});
         wr_reg(8'hE8, 8'hC0);
         rd_chk(8'hE8, 8'h80);
         wr_reg(8'hE8, 8'h00);
      end
      $display("t_cmp done");
   endtask
   task automatic t_gate();
      sw_conv(8'h01, 8'h20, 12'h050, 12'h300);
      cmp(go_cnt - base_go, 12'h002);
      cmp(conversion_result, 12'h300);
      rd_chk(8'hE2, 8'h30);
      wr_reg(8'hE8, 8'h00);
      $display("t_gate done");
   endtask
   task automatic t_ext();
      wr_reg(8'hE8, 8'h30);
      wr_reg(8'hE3, 8'h03);
      wr_reg(8'hE2, 8'h01);
      wr_reg(8'hE1, 8'h05);
      base_go = go_cnt;
      pin_p04 = 1'b1;
      cycles(40);
      cmp(go_cnt - base_go, 12'h000);
      pin_p04 = 1'b0;
      wr_reg(8'hE1, 8'h07);
      cycles(10);
      pin_p04 = 1'b1;
      cycles(20);
      pin_p04 = 1'b0;
      cycles(5);
      pin_p04 = 1'b1;
      cycles(200);
      cmp(go_cnt - base_go, 12'h000);
      wait_done();
      cmp(go_cnt - base_go, 12'h001);
      wr_reg(8'hE8, 8'h30);
      cycles(300);
      cmp(go_cnt - base_go, 12'h001);
      // Both pins low first: rerouting alone makes an edge
      pin_p04 = 1'b0;
      cycles(10);
      wr_reg(8'hE2, 8'h00);
      wr_reg(8'hE1, 8'h43);
      pin_p04 = 1'b1;
      cycles(10);
      pin_p04 = 1'b0;
      cycles(30);
      cmp(go_cnt - base_go, 12'h001);
      pin_p13 = 1'b1;
      cycles(30);
      pin_p13 = 1'b0;
      wait_done();
      cmp(go_cnt - base_go, 12'h002);
      $display("t_ext done");
   endtask
   task automatic t_pwm();
      wr_reg(8'hE8, 8'h00);
      wr_reg(8'hE1, 8'h0B);
      base_go = go_cnt;
      pwm_in.center_point = 1'b1;
      cycles(8);
      pwm_in.center_point = 1'b0;
      cycles(30);
      cmp(go_cnt - base_go, 12'h000);
      pwm_in.center_aligned = 1'b1;
      cycles(8);
      pwm_in.center_point = 1'b1;
      cycles(8);
      pwm_in.center_point = 1'b0;
      wait_done();
      cmp(go_cnt - base_go, 12'h001);
      wr_reg(8'hE8, 8'h00);
      wr_reg(8'hE1, 8'h0F);
      pwm_in.period_end = 1'b1;
      cycles(8);
      pwm_in.period_end = 1'b0;
      wait_done();
      cmp(go_cnt - base_go, 12'h002);
      wr_reg(8'hE8, 8'h10);
      wr_reg(8'hE1, 8'h07);
      pwm_in.chan = 3'b101;
      cycles(30);
      cmp(go_cnt - base_go, 12'h002);
      pwm_in.chan = 3'b111;
      wait_done();
      cmp(go_cnt - base_go, 12'h003);
      $display("t_pwm done");
   endtask

   initial begin
      #200000;
      errors++;
      $display("Error %0t watchdog expired", $time);
      summarize();
   end

   initial begin
      rst_n = 1'b0;
      sfr_req = '0;
      pwm_in = '0;
      pin_p04 = 1'b0;
      pin_p13 = 1'b1;
      res_a = 12'h000;
      res_b = 12'h000;
      base_go = 12'h000;
      repeat (20) @(posedge clk_sys);
      #1 rst_n = 1'b1;
      pin_p13 = 1'b0;
      cycles(5);
      t_regs();
      t_div();
      t_cmp();
      t_gate();
      t_ext();
      t_pwm();
      summarize();
   end
endmodule
`default_nettype wire
